//--- hw/arf_defs.svh
`ifndef ARF_DEFS_SVH
`define ARF_DEFS_SVH

// ==========================================================
// buffer geometry
`define ARF_DATA_W 32
`define ARF_RESP_W 2
`define ARF_DEPTH 16
`define ARF_AW 4
`define ARF_CNT_W 5
`define ARF_THR_W 3

// ==========================================================
// register offsets (byte addresses)
`define ARF_OFS_CTRL 12'h000
`define ARF_OFS_STATUS 12'h004
`define ARF_OFS_MASK 12'h008
`define ARF_OFS_LEVELS 12'h00C
`define ARF_OFS_THRESH 12'h010

// ==========================================================
// control fields
`define ARF_CTRL_ECC_EN 0
`define ARF_CTRL_REJ_EN 1
`define ARF_CTRL_RESET 2'h0

// ==========================================================
// status and mask fields
`define ARF_EV_HIGH 0
`define ARF_EV_LOW 1
`define ARF_EV_REJECT 2
`define ARF_EV_ERRRESP 3
`define ARF_EV_W 4
`define ARF_EV_RESET 4'h0

// ==========================================================
// level and threshold register fields
`define ARF_LVL_STORED 0
`define ARF_LVL_WRITTEN 8
`define ARF_LVL_READABLE 16
`define ARF_LVL_HIGH 24
`define ARF_LVL_LOW 25
`define ARF_THR_EMPTY 8

// ==========================================================
// injection bit positions
`define ARF_SBIT_POS 0
`define ARF_DBIT_POS 1

`endif

//--- hw/arf_pkg.sv
`default_nettype none

`include "arf_defs.svh"

package arf_pkg;

    // ==========================================================
    // one read-data beat: data word plus response
    typedef struct packed {
        logic [`ARF_DATA_W-1:0] data;
        logic [`ARF_RESP_W-1:0] resp;
    } arf_beat_t;

    // ==========================================================
    // response codes carried unchanged
    typedef enum logic [`ARF_RESP_W-1:0] {
        ARF_OKAY = 2'h0,
        ARF_EXOKAY = 2'h1,
        ARF_SLVERR = 2'h2,
        ARF_DECERR = 2'h3
    } arf_resp_t;

endpackage : arf_pkg

`default_nettype wire

//--- hw/arf_store.sv
`default_nettype none

`include "arf_defs.svh"

module arf_store (
    // clock
    input wire logic pclk,
    // write side
    input wire logic wr_en,
    input wire logic [`ARF_AW-1:0] wr_addr,
    input wire arf_pkg::arf_beat_t wr_beat,
    input wire logic inject_single,
    input wire logic inject_double,
    // read side
    input wire logic [`ARF_AW-1:0] rd_addr,
    output arf_pkg::arf_beat_t rd_beat
);

    // ==========================================================
    // storage array
    arf_pkg::arf_beat_t mem [`ARF_DEPTH];
    arf_pkg::arf_beat_t stored_beat;

    // ==========================================================
    // error injection on the stored image
    always_comb begin
        stored_beat = wr_beat;
        if (inject_single || inject_double) begin
            stored_beat.data[`ARF_SBIT_POS] = ~wr_beat.data[`ARF_SBIT_POS];
        end
        if (inject_double) begin
            stored_beat.data[`ARF_DBIT_POS] = ~wr_beat.data[`ARF_DBIT_POS];
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= stored_beat;
        end
    end

    assign rd_beat = mem[rd_addr];

endmodule : arf_store

`default_nettype wire

//--- hw/arf_top.sv
// The register addresses and register access over APB were decided locally.
`default_nettype none

`include "arf_defs.svh"

module arf_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // upstream read data port
    output logic [`ARF_DATA_W-1:0] s_axi_rdata,
    output logic [`ARF_RESP_W-1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // downstream read data port
    input wire logic [`ARF_DATA_W-1:0] m_axi_rdata,
    input wire logic [`ARF_RESP_W-1:0] m_axi_rresp,
    input wire logic m_axi_rvalid,
    output logic m_axi_rready,
    // sideband
    input wire logic [`ARF_THR_W-1:0] addr_buf_full_thresh,
    input wire logic [`ARF_THR_W-1:0] addr_buf_empty_thresh,
    input wire logic inject_single_err,
    input wire logic inject_double_err,
    output logic [`ARF_CNT_W-1:0] addr_buf_written_words,
    output logic [`ARF_CNT_W-1:0] addr_buf_readable_words,
    output logic [`ARF_CNT_W-1:0] addr_buf_stored_words,
    output logic addr_buf_read_rejected,
    output logic addr_buf_high_mark,
    output logic addr_buf_low_mark
);

    // ==========================================================
    // declarations
    logic [1:0] ctrl;
    logic [`ARF_EV_W-1:0] status;
    logic [`ARF_EV_W-1:0] mask;
    logic [`ARF_EV_W-1:0] events;
    logic [`ARF_THR_W-1:0] full_thr;
    logic [`ARF_THR_W-1:0] empty_thr;
    logic [`ARF_AW-1:0] wr_ptr;
    logic [`ARF_AW-1:0] rd_ptr;
    logic [`ARF_CNT_W-1:0] mem_cnt;
    logic [`ARF_CNT_W-1:0] next_mem_cnt;
    logic [`ARF_CNT_W-1:0] next_total;
    logic next_out_valid;
    logic push;
    logic pop;
    logic take;
    logic apb_setup;
    logic apb_wr;
    logic addr_ok;
    logic [31:0] next_prdata;
    logic high_prev;
    logic low_prev;
    arf_pkg::arf_beat_t in_beat;
    arf_pkg::arf_beat_t head_beat;

    // ==========================================================
    // handshakes
    assign push = m_axi_rvalid && m_axi_rready;
    assign take = s_axi_rvalid && s_axi_rready;
    assign pop = (mem_cnt != '0) && (!s_axi_rvalid || take);

    assign in_beat.data = m_axi_rdata;
    assign in_beat.resp = m_axi_rresp;

    // ==========================================================
    // occupancy bookkeeping
    always_comb begin
        next_mem_cnt = mem_cnt;
        if (push && !pop) begin
            next_mem_cnt = mem_cnt + `ARF_CNT_W'(1);
        end else if (!push && pop) begin
            next_mem_cnt = mem_cnt - `ARF_CNT_W'(1);
        end
    end

    assign next_out_valid = pop || (s_axi_rvalid && !take);
    assign next_total = next_mem_cnt + `ARF_CNT_W'(next_out_valid);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_cnt <= '0;
        end else begin
            mem_cnt <= next_mem_cnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + `ARF_AW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + `ARF_AW'(1);
        end
    end

    // ==========================================================
    // storage
    arf_store u_store (
        .pclk(pclk),
        .wr_en(push),
        .wr_addr(wr_ptr),
        .wr_beat(in_beat),
        .inject_single(inject_single_err && ctrl[`ARF_CTRL_ECC_EN]),
        .inject_double(inject_double_err && ctrl[`ARF_CTRL_ECC_EN]),
        .rd_addr(rd_ptr),
        .rd_beat(head_beat)
    );

    // ==========================================================
    // upstream output stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_rvalid <= next_out_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= '0;
        end else if (pop) begin
            s_axi_rdata <= head_beat.data;
            s_axi_rresp <= head_beat.resp;
        end
    end

    // ==========================================================
    // downstream acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_axi_rready <= 1'b0;
        end else begin
            m_axi_rready <= (next_mem_cnt < `ARF_CNT_W'(`ARF_DEPTH));
        end
    end

    // ==========================================================
    // occupancy counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_buf_stored_words <= '0;
        end else begin
            addr_buf_stored_words <= next_total;
        end
    end

    // ==========================================================
    // writer and reader views, one edge behind the stored count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_buf_written_words <= '0;
            addr_buf_readable_words <= '0;
        end else begin
            addr_buf_written_words <= addr_buf_stored_words;
            addr_buf_readable_words <= addr_buf_stored_words;
        end
    end

    // ==========================================================
    // thresholds, loaded while reset is held
    always_ff @(posedge pclk) begin
        if (!presetn) begin
            full_thr <= addr_buf_full_thresh;
            empty_thr <= addr_buf_empty_thresh;
        end
    end

    // ==========================================================
    // programmable marks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_buf_high_mark <= 1'b0;
            addr_buf_low_mark <= 1'b1;
        end else begin
            addr_buf_high_mark <= (next_total >= `ARF_CNT_W'(full_thr));
            addr_buf_low_mark <= (next_total <= `ARF_CNT_W'(empty_thr));
        end
    end

    // ==========================================================
    // rejected read report
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_buf_read_rejected <= 1'b0;
        end else begin
            addr_buf_read_rejected <= ctrl[`ARF_CTRL_REJ_EN] && s_axi_rready
                && !s_axi_rvalid && (mem_cnt == '0);
        end
    end

    // ==========================================================
    // interrupt events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_prev <= 1'b0;
            low_prev <= 1'b1;
        end else begin
            high_prev <= addr_buf_high_mark;
            low_prev <= addr_buf_low_mark;
        end
    end

    always_comb begin
        events = '0;
        events[`ARF_EV_HIGH] = addr_buf_high_mark && !high_prev;
        events[`ARF_EV_LOW] = addr_buf_low_mark && !low_prev;
        events[`ARF_EV_REJECT] = addr_buf_read_rejected;
        events[`ARF_EV_ERRRESP] = push && (m_axi_rresp != arf_pkg::ARF_OKAY);
    end

    // ==========================================================
    // apb decode
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        addr_ok = 1'b1;
        next_prdata = '0;
        case (paddr)
            `ARF_OFS_CTRL: begin
                next_prdata[1:0] = ctrl;
            end
            `ARF_OFS_STATUS: begin
                next_prdata[`ARF_EV_W-1:0] = status;
            end
            `ARF_OFS_MASK: begin
                next_prdata[`ARF_EV_W-1:0] = mask;
            end
            `ARF_OFS_LEVELS: begin
                next_prdata[`ARF_LVL_STORED +: `ARF_CNT_W] = addr_buf_stored_words;
                next_prdata[`ARF_LVL_WRITTEN +: `ARF_CNT_W] = addr_buf_written_words;
                next_prdata[`ARF_LVL_READABLE +: `ARF_CNT_W] = addr_buf_readable_words;
                next_prdata[`ARF_LVL_HIGH] = addr_buf_high_mark;
                next_prdata[`ARF_LVL_LOW] = addr_buf_low_mark;
            end
            `ARF_OFS_THRESH: begin
                next_prdata[0 +: `ARF_THR_W] = full_thr;
                next_prdata[`ARF_THR_EMPTY +: `ARF_THR_W] = empty_thr;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // apb answer, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_ok;
            prdata <= (apb_setup && !pwrite) ? next_prdata : 32'h00000000;
        end
    end

    // ==========================================================
    // control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `ARF_CTRL_RESET;
        end else if (apb_wr && paddr == `ARF_OFS_CTRL) begin
            ctrl <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= `ARF_EV_RESET;
        end else if (apb_wr && paddr == `ARF_OFS_MASK) begin
            mask <= pwdata[`ARF_EV_W-1:0];
        end
    end

    // ==========================================================
    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `ARF_EV_RESET;
        end else if (apb_wr && paddr == `ARF_OFS_STATUS) begin
            status <= (status & ~pwdata[`ARF_EV_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

endmodule : arf_top

`default_nettype wire

//--- sim/arf_assertions.sv
`default_nettype none
`include "arf_defs.svh"
module arf_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // read data ports
    input wire logic [`ARF_DATA_W-1:0] s_axi_rdata,
    input wire logic [`ARF_RESP_W-1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`ARF_DATA_W-1:0] m_axi_rdata,
    input wire logic [`ARF_RESP_W-1:0] m_axi_rresp,
    input wire logic m_axi_rvalid,
    input wire logic m_axi_rready,
    // sideband
    input wire logic [`ARF_THR_W-1:0] addr_buf_full_thresh,
    input wire logic [`ARF_THR_W-1:0] addr_buf_empty_thresh,
    input wire logic inject_single_err,
    input wire logic inject_double_err,
    input wire logic [`ARF_CNT_W-1:0] addr_buf_written_words,
    input wire logic [`ARF_CNT_W-1:0] addr_buf_readable_words,
    input wire logic [`ARF_CNT_W-1:0] addr_buf_stored_words,
    input wire logic addr_buf_read_rejected,
    input wire logic addr_buf_high_mark,
    input wire logic addr_buf_low_mark
);
    logic push;
    logic pop;
    logic [`ARF_CNT_W-1:0] held;
    assign push = m_axi_rvalid && m_axi_rready;
    assign pop = s_axi_rvalid && s_axi_rready;
    assign held = addr_buf_stored_words;
    // ==========================================================
    // reference occupancy and thresholds seen during reset
    logic [`ARF_CNT_W-1:0] seen_cnt;
    logic [`ARF_THR_W-1:0] full_q;
    logic [`ARF_THR_W-1:0] empty_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_cnt <= 5'h00;
        end else begin
            seen_cnt <= seen_cnt + 5'(push) - 5'(pop);
        end
    end
    always_ff @(posedge pclk) begin
        if (!presetn) begin
            full_q <= addr_buf_full_thresh;
            empty_q <= addr_buf_empty_thresh;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // steps of one beat through an empty buffer
    sequence s_take_empty;
        push && !inject_single_err && !inject_double_err && seen_cnt == 5'h00 && !s_axi_rvalid;
    endsequence
    sequence s_show;
        s_axi_rvalid && s_axi_rdata == $past(m_axi_rdata, 2)
            && s_axi_rresp == $past(m_axi_rresp, 2);
    endsequence
    // ==========================================================
    // properties
    property p_counts;
        held == seen_cnt && addr_buf_written_words >= seen_cnt - 5'($past(push))
            && addr_buf_readable_words <= seen_cnt + 5'($past(pop));
    endproperty
    property p_push;
        push && !pop |=> held == $past(held) + 5'h01 && addr_buf_written_words == $past(held);
    endproperty
    property p_pop;
        pop && !push |=> held == $past(held) - 5'h01 && addr_buf_readable_words == $past(held);
    endproperty
    property p_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    property p_empty;
        seen_cnt == 5'h00 |-> !s_axi_rvalid;
    endproperty
    property p_full;
        seen_cnt == 5'h11 |-> !m_axi_rready;
    endproperty
    property p_high;
        addr_buf_high_mark == (seen_cnt >= {2'h0, full_q});
    endproperty
    property p_low;
        addr_buf_low_mark == (seen_cnt <= {2'h0, empty_q});
    endproperty
    property p_reject;
        addr_buf_read_rejected |-> $past(s_axi_rready) && !$past(s_axi_rvalid);
    endproperty
    property p_pass;
        s_take_empty |-> ##2 s_show;
    endproperty
    a_counts: assert property (p_counts) else $error("count bounds broken");
    a_push: assert property (p_push) else $error("push not counted");
    a_pop: assert property (p_pop) else $error("pop not counted");
    a_hold: assert property (p_hold) else $error("upstream beat changed");
    a_empty: assert property (p_empty) else $error("valid while empty");
    a_full: assert property (p_full) else $error("ready while full");
    a_high: assert property (p_high) else $error("high mark wrong");
    a_low: assert property (p_low) else $error("low mark wrong");
    a_reject: assert property (p_reject) else $error("reject without cause");
    a_pass: assert property (p_pass) else $error("beat not passed");
endmodule : arf_assertions

bind arf_top arf_assertions i_chk (
    .pclk(pclk), .presetn(presetn),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .m_axi_rdata(m_axi_rdata), .m_axi_rresp(m_axi_rresp), .m_axi_rvalid(m_axi_rvalid),
    .m_axi_rready(m_axi_rready),
    .addr_buf_full_thresh(addr_buf_full_thresh),
    .addr_buf_empty_thresh(addr_buf_empty_thresh),
    .inject_single_err(inject_single_err), .inject_double_err(inject_double_err),
    .addr_buf_written_words(addr_buf_written_words),
    .addr_buf_readable_words(addr_buf_readable_words),
    .addr_buf_stored_words(addr_buf_stored_words),
    .addr_buf_read_rejected(addr_buf_read_rejected),
    .addr_buf_high_mark(addr_buf_high_mark), .addr_buf_low_mark(addr_buf_low_mark)
);
`default_nettype wire

//--- sim/arf_partner.sv
`default_nettype none
module arf_partner (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // test control
    input wire logic take_en,
    input wire logic slow,
    // upstream sink
    input wire arf_pkg::arf_beat_t up_beat,
    input wire logic up_valid,
    output logic up_ready,
    // downstream source
    output arf_pkg::arf_beat_t dn_beat,
    output logic dn_valid,
    input wire logic dn_ready
);
    arf_pkg::arf_beat_t tx_q[$];
    arf_pkg::arf_beat_t rx_q[$];
    logic gap;
    // ==========================================================
    // source holds each beat until taken, scrambles when idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dn_valid <= 1'b0;
            dn_beat <= '0;
            gap <= 1'b0;
        end else begin
            gap <= slow & ~gap;
            if (!dn_valid || dn_ready) begin
                if (tx_q.size() > 0 && !(slow && gap)) begin
                    dn_beat <= tx_q.pop_front();
                    dn_valid <= 1'b1;
                end else begin
                    dn_valid <= 1'b0;
                    dn_beat <= ~dn_beat;
                end
            end
        end
    end
    // ==========================================================
    // sink takes beats when enabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ready <= 1'b0;
        end else begin
            up_ready <= take_en && !(slow && gap);
            if (up_valid && up_ready) begin
                rx_q.push_back(up_beat);
            end
        end
    end
endmodule : arf_partner
`default_nettype wire

//--- sim/arf_top_tb.sv
`default_nettype none
`include "arf_defs.svh"
module arf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid, s_axi_rready, m_axi_rready, dn_valid, take_en, slow;
    logic [2:0] addr_buf_full_thresh, addr_buf_empty_thresh;
    logic inject_single_err, inject_double_err;
    logic [4:0] addr_buf_written_words, addr_buf_readable_words, addr_buf_stored_words;
    logic addr_buf_read_rejected, addr_buf_high_mark, addr_buf_low_mark;
    arf_pkg::arf_beat_t dn_beat;
    int n_errors = 0;
    int checked = 0;
    int k;
    always #2.5 pclk = ~pclk;
    arf_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .m_axi_rdata(dn_beat.data), .m_axi_rresp(dn_beat.resp), .m_axi_rvalid(dn_valid),
        .m_axi_rready, .addr_buf_full_thresh, .addr_buf_empty_thresh, .inject_single_err,
        .inject_double_err, .addr_buf_written_words, .addr_buf_readable_words,
        .addr_buf_stored_words, .addr_buf_read_rejected, .addr_buf_high_mark,
        .addr_buf_low_mark);
    arf_partner i_part (.pclk, .presetn, .take_en, .slow, .up_beat({s_axi_rdata, s_axi_rresp}),
        .up_valid(s_axi_rvalid), .up_ready(s_axi_rready), .dn_beat, .dn_valid,
        .dn_ready(m_axi_rready));
    // ==========================================================
    // helpers
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick;
        @(posedge pclk);
        k++;
        if (k > 400) begin
            n_errors++;
            end_sim();
        end
    endtask : tick
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do tick(); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({2'h0, rd}, {2'h0, exp});
    endtask : rd_chk
    task automatic wait_rx(input int n);
        k = 0;
        while (i_part.rx_q.size() < n) tick();
    endtask : wait_rx
    function automatic arf_pkg::arf_beat_t beat(input int i);
        return {32'hC0DE_0000 | 32'(i), 2'(i)};
    endfunction : beat
    // ==========================================================
    // tests
    initial begin
        {presetn, psel, penable, pwrite, take_en, slow} = 6'h0;
        {inject_single_err, inject_double_err, paddr, pwdata} = '0;
        addr_buf_full_thresh = 3'h6;
        addr_buf_empty_thresh = 3'h2;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        addr_buf_full_thresh <= 3'h1;
        addr_buf_empty_thresh <= 3'h5;
        chk({33'h0, m_axi_rready}, 34'h1);
        rd_chk(`ARF_OFS_LEVELS, 32'h0200_0000);
        rd_chk(`ARF_OFS_THRESH, 32'h0000_0206);
        apb(1'b0, 12'h020, 32'h0);
        chk({33'h0, err}, 34'h1);
        $display("reset test done");
        for (int i = 0; i < 4; i++) i_part.tx_q.push_back(beat(i));
        take_en <= 1'b1;
        wait_rx(4);
        for (int i = 0; i < 4; i++) chk(i_part.rx_q[i], beat(i));
        rd_chk(`ARF_OFS_STATUS, 32'h0000_0008);
        apb(1'b1, `ARF_OFS_MASK, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        chk({33'h0, irq}, 34'h1);
        apb(1'b1, `ARF_OFS_STATUS, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        chk({33'h0, irq}, 34'h0);
        $display("response test done");
        i_part.rx_q.delete();
        take_en <= 1'b0;
        slow <= 1'b1;
        for (int i = 8; i < 28; i++) i_part.tx_q.push_back(beat(i));
        k = 0;
        while (addr_buf_stored_words !== 5'h11) tick();
        repeat (4) @(posedge pclk);
        chk({31'h0, m_axi_rready, addr_buf_high_mark, addr_buf_low_mark}, 34'h2);
        rd_chk(`ARF_OFS_LEVELS, 32'h0111_1111);
        take_en <= 1'b1;
        wait_rx(20);
        for (int i = 0; i < 20; i++) chk(i_part.rx_q[i], beat(i + 8));
        repeat (2) @(posedge pclk);
        chk({29'h0, addr_buf_stored_words}, 34'h0);
        chk({33'h0, addr_buf_low_mark}, 34'h1);
        rd_chk(`ARF_OFS_STATUS, 32'h0000_000B);
        $display("fill test done");
        slow <= 1'b0;
        apb(1'b1, `ARF_OFS_CTRL, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk({33'h0, addr_buf_read_rejected}, 34'h1);
        chk({29'h0, addr_buf_stored_words}, 34'h0);
        $display("reject test done");
        apb(1'b1, `ARF_OFS_CTRL, 32'h0000_0001);
        for (int j = 0; j < 2; j++) begin
            i_part.rx_q.delete();
            inject_single_err <= (j == 0);
            inject_double_err <= (j == 1);
            i_part.tx_q.push_back({32'h0000_00F0, 2'h0});
            wait_rx(1);
            chk(i_part.rx_q[0], {32'h0000_00F0 ^ (j == 0 ? 32'h1 : 32'h3), 2'h0});
        end
        $display("inject test done");
        end_sim();
    end
endmodule : arf_top_tb
`default_nettype wire
